// file: common/sdi_pkg.sv
// constants shared by the serial converter input register block
package sdi_pkg;

  // ****************************************************************
  // data widths
  // ****************************************************************
  localparam int          CODE_W      = 12;
  localparam int          CNT_W       = 5;
  localparam int          PIN_W       = 8;
  localparam int          ADDR_W      = 4;
  localparam int          DATA_W      = 32;

  // ****************************************************************
  // pin bank bit positions
  // ****************************************************************
  localparam int          PIN_RISE_A  = 0;
  localparam int          PIN_RISE_B  = 1;
  localparam int          PIN_RISE_C  = 2;
  localparam int          PIN_FALL    = 3;
  localparam int          PIN_XFER_A  = 4;
  localparam int          PIN_XFER_B  = 5;
  localparam int          PIN_SERIAL  = 6;
  localparam int          PIN_ZERO    = 7;
  // idle levels: rising strobes low, falling strobe high, enables high, clear high
  localparam logic [7:0]  PIN_IDLE    = 8'hB8;

  // ****************************************************************
  // register map (byte addresses)
  // ****************************************************************
  localparam logic [3:0]  OFS_CTRL    = 4'h0;
  localparam logic [3:0]  OFS_INPUT   = 4'h4;
  localparam logic [3:0]  OFS_CODE    = 4'h8;
  localparam logic [3:0]  OFS_COUNT   = 4'hC;

  // control fields and reset value
  localparam int          CTRL_SHIFT_EN = 0;
  localparam int          CTRL_XFER_EN  = 1;
  localparam logic [1:0]  CTRL_RESET    = 2'h3;

  localparam logic [11:0] CODE_ZERO   = 12'h000;
  localparam logic [4:0]  COUNT_MAX   = 5'h1F;

endpackage

// file: logic/sdi_pin_sync.sv
// two-flop synchroniser bank for the interface pins, plus a delayed copy for edges
`timescale 1ns/1ps
module sdi_pin_sync (
  // clock and reset
  input  wire logic                      ref_clk,
  input  wire logic                      rst,
  // raw pins
  input  wire logic [sdi_pkg::PIN_W-1:0] pinRaw,
  // synchronised level and its value one cycle earlier
  output logic      [sdi_pkg::PIN_W-1:0] pinSync,
  output logic      [sdi_pkg::PIN_W-1:0] pinPrev
);

  logic [sdi_pkg::PIN_W-1:0] meta_r;
  logic [sdi_pkg::PIN_W-1:0] sync_r;
  logic [sdi_pkg::PIN_W-1:0] prev_r;
  logic [sdi_pkg::PIN_W-1:0] meta_nxt;
  logic [sdi_pkg::PIN_W-1:0] sync_nxt;
  logic [sdi_pkg::PIN_W-1:0] prev_nxt;

  // first stage feeds only the second stage
  always_comb begin
    meta_nxt = pinRaw;
    sync_nxt = meta_r;
    prev_nxt = sync_r;
    if (rst) begin
      meta_nxt = sdi_pkg::PIN_IDLE;
      sync_nxt = sdi_pkg::PIN_IDLE;
      prev_nxt = sdi_pkg::PIN_IDLE;
    end
  end

  always_ff @(posedge ref_clk) begin
    meta_r <= meta_nxt;
    sync_r <= sync_nxt;
    prev_r <= prev_nxt;
  end

  assign pinSync = sync_r;
  assign pinPrev = prev_r;

endmodule

// file: logic/sdi_input_regs.sv
// serial input shift register, converter register and Avalon-MM register slave
//
// Added by the designer: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
module sdi_input_regs (
  // clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       rst,
  // strobe, transfer and clear pins
  input  wire logic                       shift_strobe_rise_a,
  input  wire logic                       shift_strobe_rise_b,
  input  wire logic                       shift_strobe_rise_c,
  input  wire logic                       shift_strobe_fall,
  input  wire logic                       transfer_enable_n_a,
  input  wire logic                       transfer_enable_n_b,
  input  wire logic                       zero_output_n,
  input  wire logic                       serial_bit_in,
  // converter switch controls
  output logic      [sdi_pkg::CODE_W-1:0] dacCode,
  // avalon-mm slave
  input  wire logic [sdi_pkg::ADDR_W-1:0] address,
  input  wire logic                       read,
  input  wire logic                       write,
  input  wire logic [sdi_pkg::DATA_W-1:0] writedata,
  input  wire logic [3:0]                 byteenable,
  output logic      [sdi_pkg::DATA_W-1:0] readdata,
  output logic                            waitrequest
);

  // ****************************************************************
  // pin synchronisation and edge detection
  // ****************************************************************
  logic [sdi_pkg::PIN_W-1:0] pinSync;
  logic [sdi_pkg::PIN_W-1:0] pinPrev;

  sdi_pin_sync u_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .pinRaw  ({zero_output_n, serial_bit_in, transfer_enable_n_b, transfer_enable_n_a,
               shift_strobe_fall, shift_strobe_rise_c, shift_strobe_rise_b, shift_strobe_rise_a}),
    .pinSync (pinSync),
    .pinPrev (pinPrev)
  );

  logic riseA;
  logic riseB;
  logic riseC;
  logic fallS;
  logic idleA;
  logic idleB;
  logic idleC;
  logic idleF;
  logic shiftEvent;
  logic xferCond;

  logic [1:0]                 ctrl_r;
  logic [1:0]                 ctrl_nxt;
  logic [sdi_pkg::CODE_W-1:0] inReg_r;
  logic [sdi_pkg::CODE_W-1:0] inReg_nxt;
  logic [sdi_pkg::CODE_W-1:0] code_r;
  logic [sdi_pkg::CODE_W-1:0] code_nxt;
  logic [sdi_pkg::CNT_W-1:0]  count_r;
  logic [sdi_pkg::CNT_W-1:0]  count_nxt;
  logic                       resp_r;
  logic                       resp_nxt;
  logic [sdi_pkg::DATA_W-1:0] rdata_r;
  logic [sdi_pkg::DATA_W-1:0] rdata_nxt;

  // a strobe only counts while both its samples agree the others sit idle
  always_comb begin
    idleA      = !pinSync[sdi_pkg::PIN_RISE_A] && !pinPrev[sdi_pkg::PIN_RISE_A];
    idleB      = !pinSync[sdi_pkg::PIN_RISE_B] && !pinPrev[sdi_pkg::PIN_RISE_B];
    idleC      = !pinSync[sdi_pkg::PIN_RISE_C] && !pinPrev[sdi_pkg::PIN_RISE_C];
    idleF      = pinSync[sdi_pkg::PIN_FALL] && pinPrev[sdi_pkg::PIN_FALL];
    riseA      = pinSync[sdi_pkg::PIN_RISE_A] && !pinPrev[sdi_pkg::PIN_RISE_A];
    riseB      = pinSync[sdi_pkg::PIN_RISE_B] && !pinPrev[sdi_pkg::PIN_RISE_B];
    riseC      = pinSync[sdi_pkg::PIN_RISE_C] && !pinPrev[sdi_pkg::PIN_RISE_C];
    fallS      = !pinSync[sdi_pkg::PIN_FALL] && pinPrev[sdi_pkg::PIN_FALL];
    // any other strobe held active blocks the edge
    shiftEvent = ctrl_r[sdi_pkg::CTRL_SHIFT_EN] &&
                 ((riseA && idleB && idleC && idleF) ||
                  (riseB && idleA && idleC && idleF) ||
                  (riseC && idleA && idleB && idleF) ||
                  (fallS && idleA && idleB && idleC));
    // both enables low together with clear high
    xferCond   = ctrl_r[sdi_pkg::CTRL_XFER_EN] && pinSync[sdi_pkg::PIN_ZERO] &&
                 !pinSync[sdi_pkg::PIN_XFER_A] && !pinSync[sdi_pkg::PIN_XFER_B];
  end

  // ****************************************************************
  // input shift register and converter register
  // ****************************************************************
  always_comb begin
    inReg_nxt = inReg_r;
    count_nxt = count_r;
    code_nxt  = code_r;
    if (shiftEvent) begin
      // msb first: earlier bits move up
      inReg_nxt = {inReg_r[sdi_pkg::CODE_W-2:0], pinSync[sdi_pkg::PIN_SERIAL]};
      if (count_r != sdi_pkg::COUNT_MAX) begin
        count_nxt = count_r + 5'h01;
      end
    end
    if (xferCond) begin
      code_nxt  = inReg_r;
      count_nxt = shiftEvent ? 5'h01 : 5'h00;
    end
    // otherwise hold
    if (rst) begin
      inReg_nxt = sdi_pkg::CODE_ZERO;
      count_nxt = 5'h00;
      code_nxt  = sdi_pkg::CODE_ZERO;
    end
  end

  // clear never touches the shift register
  always_ff @(posedge ref_clk) begin
    inReg_r <= inReg_nxt;
    count_r <= count_nxt;
  end

  // clear acts without the clock; its release is not synchronised, so a transfer
  // landing on the release edge may be lost
  always_ff @(posedge ref_clk or negedge zero_output_n) begin
    if (!zero_output_n) begin
      code_r <= sdi_pkg::CODE_ZERO;
    end else begin
      code_r <= code_nxt;
    end
  end

  assign dacCode = code_r;

  // ****************************************************************
  // avalon-mm slave: one wait state, then answer
  // ****************************************************************
  function automatic logic [31:0] read_mux(input logic [3:0] ofs, input logic [1:0] ctl,
                                           input logic [11:0] inp, input logic [11:0] cod,
                                           input logic [4:0] cnt);
    logic [31:0] v;
    v = 32'h00000000;
    case (ofs)
      sdi_pkg::OFS_CTRL:  v = {30'h00000000, ctl};
      sdi_pkg::OFS_INPUT: v = {20'h00000, inp};
      sdi_pkg::OFS_CODE:  v = {20'h00000, cod};
      sdi_pkg::OFS_COUNT: v = {27'h0000000, cnt};
      default:            v = 32'h00000000;
    endcase
    return v;
  endfunction

  always_comb begin
    resp_nxt  = (read || write) && !resp_r;
    rdata_nxt = rdata_r;
    ctrl_nxt  = ctrl_r;
    if (read && !resp_r) begin
      rdata_nxt = read_mux(address, ctrl_r, inReg_r, code_r, count_r);
    end
    if (write && resp_r && address == sdi_pkg::OFS_CTRL && byteenable[0]) begin
      ctrl_nxt = writedata[1:0];
    end
    if (rst) begin
      resp_nxt  = 1'b0;
      rdata_nxt = 32'h00000000;
      ctrl_nxt  = sdi_pkg::CTRL_RESET;
    end
  end

  always_ff @(posedge ref_clk) begin
    resp_r  <= resp_nxt;
    rdata_r <= rdata_nxt;
    ctrl_r  <= ctrl_nxt;
  end

  assign waitrequest = (read || write) && !resp_r;
  assign readdata    = rdata_r;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence xfer_window_s;
    xferCond && zero_output_n ##1 zero_output_n;
  endsequence

  sequence bus_req_s;
    (read || write) && !resp_r;
  endsequence

  shift_rise_a: assert property (riseA && idleB && idleC && idleF && ctrl_r[0] |=>
    inReg_r == {$past(inReg_r[10:0]), $past(pinSync[sdi_pkg::PIN_SERIAL])})
    else $error("rising strobe did not shift the serial bit");

  shift_fall_a: assert property (fallS && idleA && idleB && idleC && ctrl_r[0] |=>
    inReg_r == {$past(inReg_r[10:0]), $past(pinSync[sdi_pkg::PIN_SERIAL])})
    else $error("falling strobe did not shift the serial bit");

  shift_rise_bc_a: assert property (ctrl_r[sdi_pkg::CTRL_SHIFT_EN] &&
    ((riseB && idleA && idleC && idleF) || (riseC && idleA && idleB && idleF)) |=>
    inReg_r == {$past(inReg_r[10:0]), $past(pinSync[sdi_pkg::PIN_SERIAL])})
    else $error("rising strobe did not shift the serial bit");

  // any strobe sitting at its active level in both samples blocks every shift
  shift_inhibit_a: assert property (
    ((pinSync[sdi_pkg::PIN_RISE_A] && pinPrev[sdi_pkg::PIN_RISE_A]) ||
     (pinSync[sdi_pkg::PIN_RISE_B] && pinPrev[sdi_pkg::PIN_RISE_B]) ||
     (pinSync[sdi_pkg::PIN_RISE_C] && pinPrev[sdi_pkg::PIN_RISE_C]) ||
     (!pinSync[sdi_pkg::PIN_FALL] && !pinPrev[sdi_pkg::PIN_FALL])) |-> !shiftEvent)
    else $error("shift taken while a strobe was held active");

  shift_hold_a: assert property (!shiftEvent |=> $stable(inReg_r))
    else $error("input register changed without a shift");

  load_copy_a: assert property (xfer_window_s |-> dacCode == $past(inReg_r))
    else $error("transfer did not copy the input register");

  load_hold_a: assert property (!xferCond && zero_output_n ##1 zero_output_n |-> $stable(dacCode))
    else $error("converter register changed without a transfer");

  clear_zero_a: assert property (!zero_output_n |-> dacCode == sdi_pkg::CODE_ZERO)
    else $error("clear did not zero the converter register");

  bus_answer_a: assert property (bus_req_s |=> !waitrequest [*1] ##1 !resp_r)
    else $error("bus answer not given after one wait state");

endmodule

// file: dv/sdi_host_model.sv
// host model that drives the serial strobes, transfer enables and clear
`timescale 1ns/1ps
module sdi_host_model (
  // clock
  input  wire logic       ref_clk,
  // pin bank, bit positions as in the package
  output logic      [7:0] pins
);
  initial pins = sdi_pkg::PIN_IDLE;

  // ****************************************************************
  // pin tasks
  // ****************************************************************
  task automatic setpin(input int idx, input logic v, input int n);
    pins[idx] <= v;
    repeat (n) @(posedge ref_clk);
  endtask

  // one bit per 200 ns link period; data is held 4 cycles either side of the edge
  task automatic strobe(input int sel, input logic b);
    setpin(sdi_pkg::PIN_SERIAL, b, 4);
    setpin(sel, ~pins[sel], 4);
    setpin(sel, ~pins[sel], 0);
  endtask

  // other strobes keep their present level, idle unless a test holds one
  task automatic send(input int sel, input logic [11:0] w);
    for (int i = 11; i >= 0; i--) begin
      strobe(sel, w[i]);
    end
    // released data line shows the inverse, not the last bit
    setpin(sdi_pkg::PIN_SERIAL, ~w[0], 4);
  endtask

  // enables take the given levels together for 8 cycles, then both return high for 8 more
  task automatic load(input logic a, input logic b);
    setpin(sdi_pkg::PIN_XFER_A, a, 0);
    setpin(sdi_pkg::PIN_XFER_B, b, 8);
    setpin(sdi_pkg::PIN_XFER_A, 1'h1, 0);
    setpin(sdi_pkg::PIN_XFER_B, 1'h1, 8);
  endtask
endmodule

// file: dv/sdi_input_regs_tb_top.sv
// self-checking testbench for the serial converter input registers
`timescale 1ns/1ps
module sdi_input_regs_tb_top;
  logic        ref_clk;
  logic        rst;
  logic        read;
  logic        write;
  logic        waitrequest;
  logic [3:0]  address;
  logic [3:0]  byteenable;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic [31:0] rd;
  logic [11:0] dacCode;
  logic [7:0]  pins;
  logic [11:0] words [4] = '{12'hA5C, 12'h3C7, 12'hF01, 12'h8E4};
  int          failCount;
  int          compares;

  initial begin
    ref_clk = 1'h0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  sdi_host_model u_host (.ref_clk(ref_clk), .pins(pins));

  sdi_input_regs u_dut (
    .ref_clk(ref_clk), .rst(rst),
    .shift_strobe_rise_a(pins[sdi_pkg::PIN_RISE_A]), .shift_strobe_rise_b(pins[sdi_pkg::PIN_RISE_B]),
    .shift_strobe_rise_c(pins[sdi_pkg::PIN_RISE_C]), .shift_strobe_fall(pins[sdi_pkg::PIN_FALL]),
    .transfer_enable_n_a(pins[sdi_pkg::PIN_XFER_A]), .transfer_enable_n_b(pins[sdi_pkg::PIN_XFER_B]),
    .zero_output_n(pins[sdi_pkg::PIN_ZERO]), .serial_bit_in(pins[sdi_pkg::PIN_SERIAL]),
    .dacCode(dacCode), .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest));

  // ****************************************************************
  // bus and compare tasks
  // ****************************************************************
  task automatic summarize;
    $display("comparisons %0d, mismatches %0d", compares, failCount);
    if (failCount == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      failCount++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // an edge passes first so a request is never raised in the step that released the last
  // waitrequest and readdata are taken at the rising edge, before that edge updates them
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    address <= a;
    write <= wr;
    read <= ~wr;
    writedata <= d;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (waitrequest !== 1'h0 && n < 100);
    if (waitrequest !== 1'h0) begin
      failCount++;
      summarize();
    end else begin
      rd = readdata;
      read <= 1'h0;
      write <= 1'h0;
    end
  endtask

  task automatic rdchk(input string what, input logic [3:0] a, input logic [31:0] exp);
    bus(1'h0, a, 32'h0);
    check(what, exp, rd);
  endtask

  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    rst = 1'h1;
    read = 1'h0;
    write = 1'h0;
    address = 4'h0;
    writedata = 32'h0;
    byteenable = 4'hF;
    failCount = 0;
    compares = 0;
    repeat (12) @(posedge ref_clk);
    rst <= 1'h0;
    repeat (4) @(posedge ref_clk);
    rdchk("ctrl", sdi_pkg::OFS_CTRL, 32'h3);
    rdchk("input", sdi_pkg::OFS_INPUT, 32'h0);
    rdchk("unmapped", 4'h2, 32'h0);
    check("dacCode", 32'h0, {20'h0, dacCode});
    $display("test reset done");
    for (int s = 0; s < 4; s++) begin
      u_host.send(s, words[s]);
      rdchk("input", sdi_pkg::OFS_INPUT, {20'h0, words[s]});
    end
    u_host.load(1'h0, 1'h0);
    check("dacCode", {20'h0, words[3]}, {20'h0, dacCode});
    rdchk("code", sdi_pkg::OFS_CODE, {20'h0, words[3]});
    $display("test shift and transfer done");
    u_host.send(0, 12'h123);
    rdchk("count", sdi_pkg::OFS_COUNT, 32'hC);
    u_host.load(1'h0, 1'h1);
    check("dacCode", {20'h0, words[3]}, {20'h0, dacCode});
    u_host.load(1'h1, 1'h0);
    check("dacCode", {20'h0, words[3]}, {20'h0, dacCode});
    $display("test single enable done");
    u_host.setpin(sdi_pkg::PIN_ZERO, 1'h0, 1);
    check("dacCode", 32'h0, {20'h0, dacCode});
    u_host.load(1'h0, 1'h0);
    check("dacCode", 32'h0, {20'h0, dacCode});
    u_host.setpin(sdi_pkg::PIN_ZERO, 1'h1, 4);
    rdchk("input", sdi_pkg::OFS_INPUT, 32'h123);
    u_host.load(1'h0, 1'h0);
    check("dacCode", 32'h123, {20'h0, dacCode});
    $display("test clear done");
    // the edges that take a strobe to its held level still shift: two low bits go in
    u_host.setpin(sdi_pkg::PIN_RISE_B, 1'h1, 4);
    u_host.send(0, 12'hFFF);
    u_host.setpin(sdi_pkg::PIN_RISE_B, 1'h0, 4);
    u_host.setpin(sdi_pkg::PIN_FALL, 1'h0, 4);
    u_host.send(2, 12'hEEE);
    u_host.setpin(sdi_pkg::PIN_FALL, 1'h1, 4);
    rdchk("input", sdi_pkg::OFS_INPUT, 32'h48C);
    $display("test held strobe done");
    bus(1'h1, sdi_pkg::OFS_CTRL, 32'h2);
    u_host.send(0, 12'h555);
    rdchk("input", sdi_pkg::OFS_INPUT, 32'h48C);
    bus(1'h1, sdi_pkg::OFS_CTRL, 32'h3);
    rdchk("ctrl", sdi_pkg::OFS_CTRL, 32'h3);
    $display("test control done");
    summarize();
  end
endmodule
